/* rtl/gwcfg_pkg.sv */
// package of constants for the gateway configuration and node scan block
// Functional notes
// - slave address from eight binary switches
// - address clamped to range 1 to 247
// - four switch-selected bit rates
// - fixed 4 ms reply delay at 9600
// - 2 ms default, written delay of 2 to 100 ms honoured
// - framing 8N2 or 8E1 by switch four
// - node LED lit, flashing or dark
// - node map discovered continuously, never stored
// - read identity when node first detected
// - drop silent node after 10 seconds
// - held confirm key enters assignment, first LED lit
// - up and down keys select target node
// - confirm starts sequence, acknowledge within 4 minutes
// - success flashes selected LED rapidly, then normal
// - confirm aborts; no address removal
// - only function codes 3 and 6 supported
// - twenty registers per node block
package gwcfg_pkg;
   // ----------------------------------------------------------------
   // clock and times
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned DLY_9600_MS    = 4;
   localparam int unsigned DLY_DEF_MS     = 2;
   localparam int unsigned DLY_MAX_MS     = 100;
   localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
   localparam int unsigned NODE_LOSS_S    = 10;
   localparam int unsigned ASSIGN_TMO_MIN = 4;
   localparam int unsigned KEY_HOLD_MS    = 2000;
   localparam int unsigned FLASH_SLOW_MS  = 250;
   localparam int unsigned FLASH_FAST_MS  = 62;
   localparam int unsigned SUCCESS_MS     = 2000;
   localparam int unsigned MS_PER_S       = 1000;
   // ----------------------------------------------------------------
   // addresses, rates, framing, function codes
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_MIN = 8'h01;
   localparam logic [7:0] ADDR_MAX = 8'hf7;
   localparam logic [1:0] BAUD_9600  = 2'h0;
   localparam logic [1:0] BAUD_19200 = 2'h1;
   localparam logic [1:0] BAUD_38400 = 2'h2;
   localparam logic [1:0] BAUD_76800 = 2'h3;
   localparam int unsigned BAUD_BASE = 9600;
   localparam int unsigned STOP_BITS_NONE = 2;
   localparam int unsigned STOP_BITS_EVEN = 1;
   localparam int unsigned FRAME_SW_BIT   = 3;
   localparam logic [7:0] FC_READ_HOLD  = 8'h03;
   localparam logic [7:0] FC_WRITE_ONE  = 8'h06;
   localparam logic [7:0] REGS_PER_NODE = 8'h14;
   localparam logic [7:0] REG_TYPE_OFS  = 8'h0c;
   localparam int unsigned NODE_CNT = 8;
   // ----------------------------------------------------------------
   // assignment state machine, gray coded along the usual path
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      GW_NORMAL  = 3'b000,
      GW_ENTER   = 3'b001,
      GW_SELECT  = 3'b011,
      GW_WAITACK = 3'b010,
      GW_SUCCESS = 3'b110
   } gwcfg_state_t;
endpackage : gwcfg_pkg

/* rtl/gwcfg_node_slot.sv */
// one node slot: presence, loss timeout, identity fetch and LED pattern
`timescale 1ns/10ps
`default_nettype none
module gwcfg_node_slot #(
   parameter int unsigned LOSS_CYC = 1_000_000_000
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic srst,
   // node bus events
   input  wire logic seen,
   input  wire logic busy,
   input  wire logic idDone,
   // shared blink phase
   input  wire logic blink,
   // status
   output logic      present,
   output logic      idReq,
   output logic      dropPulse,
   output logic      led
);
   // elaboration guard: a one-cycle window would drop a node it has just seen
   if (LOSS_CYC < 2)
   begin : g_bad_loss
      $error("loss count too short");
   end

   logic [31:0] lossCnt_q;
   logic        present_q;
   logic        idReq_q;
   logic        drop_q;

   // presence and loss counter; contact restarts the window
   always_ff @(posedge clk_sys)
   begin
      drop_q <= 1'b0;
      if (srst)
      begin
         present_q <= 1'b0;
         lossCnt_q <= 32'h0;
      end
      else if (seen)
      begin
         present_q <= 1'b1;
         lossCnt_q <= 32'h0;
      end
      else if (present_q)
      begin
         if (lossCnt_q == LOSS_CYC - 1)
         begin
            present_q <= 1'b0;
            lossCnt_q <= 32'h0;
            drop_q    <= 1'b1;
         end
         else
            lossCnt_q <= lossCnt_q + 32'h1;
      end
   end

   // identity read requested on first detection, set wins over done
   always_ff @(posedge clk_sys)
   begin
      if (srst || drop_q)
         idReq_q <= 1'b0;
      else if (seen && !present_q)
         idReq_q <= 1'b1;
      else if (idDone)
         idReq_q <= 1'b0;
   end

   assign present   = present_q;
   assign idReq     = idReq_q;
   assign dropPulse = drop_q;
   // lit when present, flashing while talking, dark when absent
   assign led = present_q & (busy ? blink : 1'b1);
endmodule : gwcfg_node_slot
`default_nettype wire

/* rtl/gwcfg_top.sv */
// gateway configuration, reply timing, node scan and address assignment
`timescale 1ns/10ps
`default_nettype none
module gwcfg_top #(
   parameter int unsigned LOSS_CYC    = gwcfg_pkg::NODE_LOSS_S * gwcfg_pkg::MS_PER_S
                                        * gwcfg_pkg::CYC_PER_MS,
   parameter longint unsigned ASSIGN_CYC = 64'(gwcfg_pkg::ASSIGN_TMO_MIN) * 64'd60
                                        * gwcfg_pkg::MS_PER_S * gwcfg_pkg::CYC_PER_MS,
   parameter int unsigned HOLD_CYC    = gwcfg_pkg::KEY_HOLD_MS * gwcfg_pkg::CYC_PER_MS,
   parameter int unsigned SLOW_CYC    = gwcfg_pkg::FLASH_SLOW_MS * gwcfg_pkg::CYC_PER_MS,
   parameter int unsigned FAST_CYC    = gwcfg_pkg::FLASH_FAST_MS * gwcfg_pkg::CYC_PER_MS,
   parameter int unsigned SUCC_CYC    = gwcfg_pkg::SUCCESS_MS * gwcfg_pkg::CYC_PER_MS,
   parameter int unsigned MS_CYC      = gwcfg_pkg::CYC_PER_MS
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        srst,
   // configuration switches
   input  wire logic [7:0]  addrSw,
   input  wire logic [1:0]  baudSw,
   input  wire logic [3:0]  cfgSw,
   // reply delay setting from the register side, in ms
   input  wire logic [7:0]  dlyWrMs,
   input  wire logic        dlyWrEn,
   // request framing from the serial engine
   input  wire logic        reqEnd,
   input  wire logic [7:0]  reqFunc,
   // front keys, one cycle pulses except confirm level
   input  wire logic        keyOk,
   input  wire logic        keyUp,
   input  wire logic        keyDown,
   // node bus events, one bit per node except the single assignAck
   input  wire logic [7:0]  nodeSeen,
   input  wire logic [7:0]  nodeBusy,
   input  wire logic [7:0]  idDone,
   input  wire logic        assignAck,
   // applied configuration
   output logic [7:0]       slaveAddr,
   output logic [17:0]      baudRate,
   output logic             parityEven,
   output logic [1:0]       stopBits,
   output logic             cfgValid,
   output logic [7:0]       replyDlyMs,
   // reply timing and function check
   output logic             replyGo,
   output logic             funcIllegal,
   // node status
   output logic [7:0]       nodePresent,
   output logic [7:0]       idReq,
   output logic [7:0]       nodeDrop,
   output logic [7:0]       node_status_indicators,
   // assignment
   output logic             assignStart,
   output logic [2:0]       assignTarget,
   output logic             assignMode
);
   // elaboration guard: every counter compares against count - 1, so zero cannot work
   if (MS_CYC < 1 || SLOW_CYC < 1 || FAST_CYC < 1 || HOLD_CYC < 1 || SUCC_CYC < 1
       || ASSIGN_CYC < 1 || LOSS_CYC < 2)
   begin : g_bad_param
      $error("bad timing parameter");
   end

   // ----------------------------------------------------------------
   // configuration capture
   // ----------------------------------------------------------------
   logic [7:0]  addr_q;
   logic [17:0] baud_q;
   logic        par_q;
   logic        valid_q;

   // taken once after reset so a switch bumped in service cannot move the slave
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         valid_q <= 1'b0;
         addr_q  <= gwcfg_pkg::ADDR_MIN;
         baud_q  <= 18'(gwcfg_pkg::BAUD_BASE);
         par_q   <= 1'b0;
      end
      else if (!valid_q)
      begin
         valid_q <= 1'b1;
         if (addrSw < gwcfg_pkg::ADDR_MIN)
            addr_q <= gwcfg_pkg::ADDR_MIN;
         else if (addrSw > gwcfg_pkg::ADDR_MAX)
            addr_q <= gwcfg_pkg::ADDR_MAX;
         else
            addr_q <= addrSw;
         baud_q <= 18'(gwcfg_pkg::BAUD_BASE) << baudSw;
         par_q  <= cfgSw[gwcfg_pkg::FRAME_SW_BIT];
      end
   end

   assign slaveAddr  = addr_q;
   assign baudRate   = baud_q;
   assign parityEven = par_q;
   assign stopBits   = par_q ? 2'(gwcfg_pkg::STOP_BITS_EVEN)
                             : 2'(gwcfg_pkg::STOP_BITS_NONE);
   assign cfgValid   = valid_q;

   // ----------------------------------------------------------------
   // reply delay
   // ----------------------------------------------------------------
   logic [7:0]  dlySet_q;
   logic [7:0]  dlyMs_q;
   logic [31:0] msCnt_q;
   logic [7:0]  msLeft_q;
   logic        dlyRun_q;
   logic        go_q;
   logic        illegal_q;

   // only a delay from the default up to 100 ms is accepted
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         dlySet_q <= 8'(gwcfg_pkg::DLY_DEF_MS);
      else if (dlyWrEn && dlyWrMs >= 8'(gwcfg_pkg::DLY_DEF_MS)
               && dlyWrMs <= 8'(gwcfg_pkg::DLY_MAX_MS))
         dlySet_q <= dlyWrMs;
   end

   always_comb
   begin
      if (baud_q == 18'(gwcfg_pkg::BAUD_BASE))
         dlyMs_q = 8'(gwcfg_pkg::DLY_9600_MS);
      else
         dlyMs_q = dlySet_q;
   end
   assign replyDlyMs = dlyMs_q;

   // delay counter runs in whole milliseconds from the end of a request
   always_ff @(posedge clk_sys)
   begin
      go_q      <= 1'b0;
      illegal_q <= 1'b0;
      if (srst)
      begin
         dlyRun_q <= 1'b0;
         msCnt_q  <= 32'h0;
         msLeft_q <= 8'h0;
      end
      else if (reqEnd && valid_q)
      begin
         dlyRun_q  <= 1'b1;
         msCnt_q   <= 32'h0;
         msLeft_q  <= dlyMs_q;
         illegal_q <= reqFunc != gwcfg_pkg::FC_READ_HOLD
                      && reqFunc != gwcfg_pkg::FC_WRITE_ONE;
      end
      else if (dlyRun_q)
      begin
         if (msCnt_q == MS_CYC - 1)
         begin
            msCnt_q <= 32'h0;
            if (msLeft_q == 8'h1)
            begin
               dlyRun_q <= 1'b0;
               go_q     <= 1'b1;
            end
            msLeft_q <= msLeft_q - 8'h1;
         end
         else
            msCnt_q <= msCnt_q + 32'h1;
      end
   end
   assign replyGo     = go_q;
   assign funcIllegal = illegal_q;

   // ----------------------------------------------------------------
   // blink phases and node slots
   // ----------------------------------------------------------------
   logic [31:0] slowCnt_q;
   logic [31:0] fastCnt_q;
   logic        slow_q;
   logic        fast_q;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         slowCnt_q <= 32'h0;
         fastCnt_q <= 32'h0;
         slow_q    <= 1'b0;
         fast_q    <= 1'b0;
      end
      else
      begin
         slowCnt_q <= (slowCnt_q == SLOW_CYC - 1) ? 32'h0 : slowCnt_q + 32'h1;
         fastCnt_q <= (fastCnt_q == FAST_CYC - 1) ? 32'h0 : fastCnt_q + 32'h1;
         if (slowCnt_q == SLOW_CYC - 1)
            slow_q <= ~slow_q;
         if (fastCnt_q == FAST_CYC - 1)
            fast_q <= ~fast_q;
      end
   end

   logic [7:0] scanLed;

   // the map lives only in these flops, rebuilt after every reset
   for (genvar n = 0; n < gwcfg_pkg::NODE_CNT; n++)
   begin : g_node
      gwcfg_node_slot #(.LOSS_CYC(LOSS_CYC)) u_slot (
         .clk_sys   (clk_sys),
         .srst      (srst),
         .seen      (nodeSeen[n]),
         .busy      (nodeBusy[n]),
         .idDone    (idDone[n]),
         .blink     (slow_q),
         .present   (nodePresent[n]),
         .idReq     (idReq[n]),
         .dropPulse (nodeDrop[n]),
         .led       (scanLed[n])
      );
   end

   // ----------------------------------------------------------------
   // address assignment
   // ----------------------------------------------------------------
   gwcfg_pkg::gwcfg_state_t st_q;
   logic [63:0] tmr_q;
   logic [2:0]  tgt_q;
   logic        okPrev_q;
   logic        start_q;
   logic        okRise;

   assign okRise = keyOk & ~okPrev_q;

   always_ff @(posedge clk_sys)
   begin
      start_q <= 1'b0;
      if (srst)
      begin
         st_q     <= gwcfg_pkg::GW_NORMAL;
         tmr_q    <= 64'h0;
         tgt_q    <= 3'h0;
         okPrev_q <= 1'b0;
      end
      else
      begin
         okPrev_q <= keyOk;
         case (st_q)
            gwcfg_pkg::GW_NORMAL:
            begin
               tgt_q <= 3'h0;
               if (keyOk)
               begin
                  if (tmr_q == 64'(HOLD_CYC) - 64'h1)
                  begin
                     st_q  <= gwcfg_pkg::GW_ENTER;
                     tmr_q <= 64'h0;
                  end
                  else
                     tmr_q <= tmr_q + 64'h1;
               end
               else
                  tmr_q <= 64'h0;
            end
            // wait for release of the held key so it is not read as confirm
            gwcfg_pkg::GW_ENTER:
               if (!keyOk)
                  st_q <= gwcfg_pkg::GW_SELECT;
            gwcfg_pkg::GW_SELECT:
            begin
               if (okRise)
               begin
                  st_q    <= gwcfg_pkg::GW_WAITACK;
                  start_q <= 1'b1;
                  tmr_q   <= 64'h0;
               end
               else if (keyUp)
                  tgt_q <= tgt_q + 3'h1;
               else if (keyDown)
                  tgt_q <= tgt_q - 3'h1;
            end
            gwcfg_pkg::GW_WAITACK:
            begin
               tmr_q <= tmr_q + 64'h1;
               if (okRise)
               begin
                  st_q  <= gwcfg_pkg::GW_NORMAL;
                  tmr_q <= 64'h0;  // a stale count would block the next hold
               end
               else if (assignAck)
               begin
                  st_q  <= gwcfg_pkg::GW_SUCCESS;
                  tmr_q <= 64'h0;
               end
               else if (tmr_q == ASSIGN_CYC - 64'h1)
               begin
                  st_q  <= gwcfg_pkg::GW_NORMAL;
                  tmr_q <= 64'h0;
               end
            end
            gwcfg_pkg::GW_SUCCESS:
            begin
               tmr_q <= tmr_q + 64'h1;
               if (tmr_q == 64'(SUCC_CYC) - 64'h1)
               begin
                  st_q  <= gwcfg_pkg::GW_NORMAL;
                  tmr_q <= 64'h0;
               end
            end
            default:
               st_q <= gwcfg_pkg::GW_NORMAL;
         endcase
      end
   end

   assign assignStart  = start_q;
   assign assignTarget = tgt_q;
   assign assignMode   = st_q != gwcfg_pkg::GW_NORMAL;

   // assignment owns the LEDs while active; scan shows otherwise
   always_comb
   begin
      node_status_indicators = scanLed;
      case (st_q)
         gwcfg_pkg::GW_ENTER:
            node_status_indicators = 8'h01;
         gwcfg_pkg::GW_SELECT,
         gwcfg_pkg::GW_WAITACK:
            node_status_indicators = 8'h01 << tgt_q;
         gwcfg_pkg::GW_SUCCESS:
            node_status_indicators = fast_q ? (8'h01 << tgt_q) : 8'h00;
         default:
            node_status_indicators = scanLed;
      endcase
   end
endmodule : gwcfg_top
`default_nettype wire

/* testbench/gwcfg_rtu_master.sv */
// bus master model: hands request ends and function codes to the block
`timescale 1ns/10ps
`default_nettype none
module gwcfg_rtu_master (
   // clock
   input  wire logic       clk_sys,
   // request framing toward the block
   output logic            reqEnd,
   output logic [7:0]      reqFunc
);
   initial
   begin
      reqEnd = 1'b0;
      reqFunc = 8'h00;
   end
   // one request end; the code is inverted once released so no stale byte lingers
   task automatic poll(input logic [7:0] func);
      @(negedge clk_sys);
      reqEnd = 1'b1;
      reqFunc = func;
      @(negedge clk_sys);
      reqEnd = 1'b0;
      reqFunc = ~func;
   endtask : poll
endmodule : gwcfg_rtu_master
`default_nettype wire

/* testbench/gwcfg_asserts.sv */
// concurrent checks on the ports of the configuration and node scan block
`timescale 1ns/10ps
`default_nettype none
module gwcfg_asserts #(
   parameter int unsigned MS_CYC   = 10,
   parameter int unsigned LOSS_CYC = 200
) (
   // watched ports
   input wire logic        clk_sys,
   input wire logic        srst,
   input wire logic [7:0]  addrSw,
   input wire logic [1:0]  baudSw,
   input wire logic [3:0]  cfgSw,
   input wire logic        reqEnd,
   input wire logic [7:0]  reqFunc,
   input wire logic [7:0]  nodeSeen,
   input wire logic [7:0]  nodeBusy,
   input wire logic [7:0]  slaveAddr,
   input wire logic [17:0] baudRate,
   input wire logic        parityEven,
   input wire logic [1:0]  stopBits,
   input wire logic        cfgValid,
   input wire logic [7:0]  replyDlyMs,
   input wire logic        replyGo,
   input wire logic        funcIllegal,
   input wire logic [7:0]  nodePresent,
   input wire logic [7:0]  idReq,
   input wire logic [7:0]  node_status_indicators,
   input wire logic        assignStart,
   input wire logic        assignMode
);
   logic        replyPend_q;
   int unsigned replyCnt_q;
   int unsigned replyTgt_q;
   int unsigned silence_q;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // reply tracker; the target is frozen at the request since the delay may change later
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         replyPend_q <= 1'b0;
      else if (reqEnd && cfgValid)
         replyPend_q <= 1'b1;
      else if (replyGo)
         replyPend_q <= 1'b0;
   end
   always_ff @(posedge clk_sys)
   begin
      if (reqEnd && cfgValid)
      begin
         replyCnt_q <= 1;
         replyTgt_q <= replyDlyMs * MS_CYC + 1;
      end
      else if (replyCnt_q < 32'h000fffff)
         replyCnt_q <= replyCnt_q + 1;
   end
   // cycles since node one was last heard
   always_ff @(posedge clk_sys)
      silence_q <= nodeSeen[0] ? 0 : silence_q + 1;
   chk_cfg_latch: assert property ($rose(cfgValid) |-> slaveAddr == ($past(addrSw) == 8'h00 ?
      8'h01 : ($past(addrSw) > 8'hf7 ? 8'hf7 : $past(addrSw))) && parityEven == $past(cfgSw[3]))
      else $error("latched address or parity wrong");
   chk_baud_pick: assert property ($rose(cfgValid) |-> baudRate == 18'(9600 << $past(baudSw)))
      else $error("bit rate does not follow switches");
   chk_stop_bits: assert property (stopBits == (parityEven ? 2'h1 : 2'h2))
      else $error("stop bits do not match parity");
   chk_delay_low: assert property (baudRate == 18'h02580 |-> replyDlyMs == 8'h04)
      else $error("slow rate delay not fixed");
   chk_func_code: assert property (reqEnd && cfgValid |=> funcIllegal ==
      ($past(reqFunc) != 8'h03 && $past(reqFunc) != 8'h06)) else $error("function check wrong");
   chk_reply_time: assert property (replyGo == (replyPend_q && replyCnt_q == replyTgt_q))
      else $error("reply moment wrong");
   chk_node_loss: assert property ($fell(nodePresent[0]) |-> silence_q + 2 >= LOSS_CYC
      && silence_q <= LOSS_CYC + 2) else $error("node dropped at wrong time");
   chk_id_fetch: assert property ($rose(nodePresent[0]) |-> ##[0:2] idReq[0])
      else $error("identity not fetched");
   chk_led_state: assert property (!assignMode && !nodeBusy[0] |->
      node_status_indicators[0] == nodePresent[0]) else $error("indicator wrong");
   chk_assign_end: assert property (assignStart |-> assignMode ##[1:560] !assignMode)
      else $error("assignment never ends");
endmodule : gwcfg_asserts
bind gwcfg_top gwcfg_asserts #(.MS_CYC(MS_CYC), .LOSS_CYC(LOSS_CYC)) u_chk (.clk_sys, .srst, .addrSw,
   .baudSw, .cfgSw, .reqEnd, .reqFunc, .nodeSeen, .nodeBusy, .slaveAddr, .baudRate, .parityEven,
   .stopBits, .cfgValid, .replyDlyMs, .replyGo, .funcIllegal, .nodePresent, .idReq,
   .node_status_indicators, .assignStart, .assignMode);
`default_nettype wire

/* testbench/gwcfg_top_tb.sv */
// self-checking bench for the configuration and node scan block
`timescale 1ns/10ps
`default_nettype none
module gwcfg_top_tb;
   localparam int MS = 10;
   logic        clk_sys = 1'b0, srst = 1'b1, dlyWrEn = 1'b0, keyOk = 1'b0, keyUp = 1'b0;
   logic        keyDown = 1'b0, assignAck = 1'b0, reqEnd, parityEven, cfgValid, replyGo;
   logic        funcIllegal, assignStart, assignMode, hit;
   logic [7:0]  addrSw = 8'h00, dlyWrMs = 8'h00, nodeSeen = 8'h00, nodeBusy = 8'h00;
   logic [7:0]  idDone = 8'h00, reqFunc, slaveAddr, replyDlyMs, nodePresent, idReq, nodeDrop;
   logic [7:0]  node_status_indicators;
   logic [1:0]  baudSw = 2'h0, stopBits;
   logic [3:0]  cfgSw = 4'h0;
   logic [17:0] baudRate;
   logic [2:0]  assignTarget;
   logic [15:0] tab [4] = '{16'h003f, 16'hff00, 16'h3517, 16'hf728};
   logic [7:0]  fc [4] = '{8'h03, 8'h06, 8'h05, 8'h10};
   int          n_fail = 0, checked = 0, n, t, e;
   always #5 clk_sys = ~clk_sys;
   gwcfg_rtu_master u_master (.clk_sys, .reqEnd, .reqFunc);
   gwcfg_top #(.LOSS_CYC(200), .ASSIGN_CYC(500), .HOLD_CYC(10), .SLOW_CYC(4), .FAST_CYC(2),
      .SUCC_CYC(20), .MS_CYC(MS)) DUT (.clk_sys, .srst, .addrSw, .baudSw, .cfgSw, .dlyWrMs,
      .dlyWrEn, .reqEnd, .reqFunc, .keyOk, .keyUp, .keyDown, .nodeSeen, .nodeBusy, .idDone,
      .assignAck, .slaveAddr, .baudRate, .parityEven, .stopBits, .cfgValid, .replyDlyMs,
      .replyGo, .funcIllegal, .nodePresent, .idReq, .nodeDrop, .node_status_indicators,
      .assignStart, .assignTarget, .assignMode);
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   task automatic wrap_up;
      $display("counts: %0d mismatches in %0d comparisons", n_fail, checked);
      if (n_fail == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_sys);
   endtask : cyc
   // switches are only read after reset, so every setting needs a fresh reset
   task automatic boot(input logic [15:0] s);
      srst = 1'b1;
      addrSw = s[15:8];
      baudSw = s[5:4];
      cfgSw  = s[3:0];
      cyc(2);
      srst = 1'b0;
      cyc(2);
   endtask : boot
   // one request, then count cycles until the reply may start
   task automatic req(input logic [7:0] f, input int d);
      u_master.poll(f);
      check(funcIllegal, f != 8'h03 && f != 8'h06);
      n = 1;
      while (!replyGo && n < 3000)
      begin
         cyc(1);
         n++;
      end
      check(n, d * MS + 1);
   endtask : req
   task automatic wrDly(input logic [7:0] v, input logic [7:0] x);
      dlyWrMs = v;
      dlyWrEn = 1'b1;
      cyc(1);
      dlyWrEn = 1'b0;
      cyc(1);
      check(replyDlyMs, x);
   endtask : wrDly
   // one-cycle press: 0 up, 1 down, 2 confirm, 3 acknowledge
   task automatic tap(input int w);
      keyUp     = w == 0;
      keyDown   = w == 1;
      keyOk     = w == 2;
      assignAck = w == 3;
      cyc(1);
      hit = assignStart;
      keyUp     = 1'b0;
      keyDown   = 1'b0;
      keyOk     = 1'b0;
      assignAck = 1'b0;
      cyc(1);
      hit = hit | assignStart;
   endtask : tap
   task automatic enter;
      keyOk = 1'b1;
      cyc(12);
      check(assignMode, 1);
      check(node_status_indicators, 8'h01);
      keyOk = 1'b0;
      cyc(1);
   endtask : enter
   task automatic togs(input int k, input int b);
      logic p;
      t = 0;
      p = node_status_indicators[b];
      repeat (k)
      begin
         cyc(1);
         t += int'(node_status_indicators[b] !== p);
         p = node_status_indicators[b];
      end
   endtask : togs
   // main sequence: switches, reply timing, node scan, address assignment
   initial
   begin
      foreach (tab[i])
      begin
         boot(tab[i]);
         e = tab[i][15:8];
         check(slaveAddr, e == 0 ? 1 : (e > 247 ? 247 : e));
         check(baudRate, 9600 << tab[i][5:4]);
         check({parityEven, stopBits}, tab[i][3] ? 3'h5 : 3'h2);
         check(cfgValid, 1);
         req(8'h03, tab[i][5:4] == 2'h0 ? 4 : 2);
      end
      wrDly(8'h64, 8'h64);
      wrDly(8'h65, 8'h64);
      wrDly(8'h01, 8'h64);
      wrDly(8'h0a, 8'h0a);
      foreach (fc[i]) req(fc[i], 10);
      nodeSeen = 8'hff;
      cyc(1);
      nodeSeen = 8'h00;
      cyc(2);
      check({nodePresent, idReq, node_status_indicators}, 24'hffffff);
      idDone = 8'hff;
      cyc(1);
      idDone = 8'h00;
      cyc(1);
      check(idReq, 8'h00);
      nodeBusy = 8'hff;
      togs(16, 0);
      check(t >= 3, 1);
      nodeBusy = 8'h00;
      cyc(150);
      nodeSeen = 8'h01;
      cyc(1);
      nodeSeen = 8'h00;
      cyc(150);
      check(nodePresent, 8'h01);
      n = 0;
      while (!nodeDrop[0] && n < 400)
      begin
         cyc(1);
         n++;
      end
      check(nodeDrop[0], 1);
      cyc(1);
      check({nodePresent[0], node_status_indicators[0]}, 0);
      enter;
      tap(0);
      tap(0);
      check({assignTarget, node_status_indicators}, {3'h2, 8'h04});
      tap(1);
      check({assignTarget, node_status_indicators}, {3'h1, 8'h02});
      tap(2);
      check(hit, 1);
      tap(3);
      togs(12, 1);
      check(t >= 5, 1);
      cyc(30);
      check(assignMode, 0);
      enter;
      tap(2);
      tap(2);
      check(assignMode, 0);
      enter;
      tap(2);
      cyc(480);
      check(assignMode, 1);
      cyc(40);
      check(assignMode, 0);
      wrap_up;
   end
   // watchdog well beyond the roughly fifteen hundred cycles the sequence needs
   initial
   begin
      #200000;
      n_fail++;
      wrap_up;
   end
endmodule : gwcfg_top_tb
`default_nettype wire
